// File: pqc_pkg.sv
package pqc_pkg;

	// Storage geometry
	localparam int unsigned QUEUE_LINES = 62;
	localparam int unsigned SEG_COUNT = 12;
	localparam int unsigned DATA_REGS = 32;
	localparam int unsigned INPUTS = 8;
	localparam logic [5:0] QUEUE_LINES_W = 6'h3e;
	localparam logic [11:0] SEG_MAX = 12'h00c;
	localparam logic [4:0] EVENT_REG = 5'h19;

	// Command codes carried in the op field
	localparam logic [3:0] OP_FILL = 4'h1;
	localparam logic [3:0] OP_STORE = 4'h2;
	localparam logic [3:0] OP_RUN = 4'h3;
	localparam logic [3:0] OP_REPEAT = 4'h4;
	localparam logic [3:0] OP_UPLOAD = 4'h5;
	localparam logic [3:0] OP_LOADRUN = 4'h6;
	localparam logic [3:0] OP_HALT = 4'h7;
	localparam logic [3:0] OP_COUNTER = 4'h8;
	localparam logic [3:0] OP_REGLOAD = 4'h9;
	localparam logic [3:0] OP_GENERIC = 4'ha;

	// Argument field layout
	localparam int unsigned ARG_REG_LSB = 6;
	localparam int unsigned ARG_TGT_MSB = 5;
	localparam int unsigned ARG_CNT_MODE_MSB = 2;
	localparam int unsigned ARG_CNT_SEL_LSB = 3;

	// Answer kinds
	localparam logic [2:0] RESP_ACK = 3'h1;
	localparam logic [2:0] RESP_NACK = 3'h2;
	localparam logic [2:0] RESP_HEADER = 3'h3;
	localparam logic [2:0] RESP_LINE = 3'h4;
	localparam logic [2:0] RESP_ERROR = 3'h5;

	// Upload error codes, two's complement
	localparam logic [15:0] ERR_EMPTY = 16'h0000;
	localparam logic [15:0] ERR_RUNNING = 16'hffff;
	localparam logic [15:0] ERR_BUSY = 16'hfffe;
	localparam logic [15:0] ERR_LOCKED = 16'hfffd;

	// Input counter modes
	localparam logic [2:0] CNT_OFF = 3'h0;
	localparam logic [2:0] CNT_RISE = 3'h1;
	localparam logic [2:0] CNT_FALL = 3'h2;
	localparam logic [2:0] CNT_LOW = 3'h3;
	localparam logic [2:0] CNT_HIGH = 3'h4;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TIMER_PERIOD_NS = 125000;
	localparam logic [11:0] TICK_CYCLES = 12'(TIMER_PERIOD_NS / CLK_PERIOD_NS);

	typedef struct packed {
		logic [3:0] op;
		logic [11:0] arg;
		logic [15:0] value;
	} pqc_cmd_t;

	typedef struct packed {
		logic valid;
		logic [2:0] kind;
		logic [15:0] value;
	} pqc_resp_t;

	typedef struct packed {
		logic valid;
		logic [15:0] line;
	} pqc_exec_t;

endpackage : pqc_pkg

// File: pqc_event_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pqc_event_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire logic cfg_valid,
	input wire logic [5:0] cfg_arg,
	// Inputs watched
	input wire logic [7:0] ev_in,
	// Increment request
	output logic inc_ff
);

	logic [2:0] mode_ff;
	logic [2:0] sel_ff;
	logic prev_ff;
	logic [11:0] tick_ff;
	logic cur;
	logic tick_done;

	assign cur = ev_in[sel_ff];
	assign tick_done = (tick_ff == pqc_pkg::TICK_CYCLES - 12'h001);

	// A zero mode switches counting off
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode_ff <= pqc_pkg::CNT_OFF;
			sel_ff <= 3'h0;
		end
		else if (cfg_valid)
		begin
			mode_ff <= cfg_arg[pqc_pkg::ARG_CNT_MODE_MSB:0];
			sel_ff <= cfg_arg[pqc_pkg::ARG_CNT_SEL_LSB +: 3];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prev_ff <= 1'b0;
		else
			prev_ff <= cur;
	end

	// Free running rate divider; restarts on reconfiguration so the first tick is a full period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tick_ff <= 12'h000;
		else if (cfg_valid || tick_done)
			tick_ff <= 12'h000;
		else
			tick_ff <= tick_ff + 12'h001;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			inc_ff <= 1'b0;
		else
		begin
			unique case (mode_ff)
				pqc_pkg::CNT_RISE: inc_ff <= cur && !prev_ff;
				pqc_pkg::CNT_FALL: inc_ff <= !cur && prev_ff;
				pqc_pkg::CNT_LOW: inc_ff <= tick_done && !cur;
				pqc_pkg::CNT_HIGH: inc_ff <= tick_done && cur;
				default: inc_ff <= 1'b0;
			endcase
		end
	end

endmodule : pqc_event_counter
`default_nettype wire

// File: pqc_queue_ctrl.sv
// Overview of operation
// - Fill command without segment stores following host commands into the queue.
// - Store or run command ends serial filling.
// - Fill with segment 1-12 copies that segment into queue from line 1.
// - Repeat jumps back to line 1-62, count taken from named data register.
// - Every repeat jump decrements the selected data register by one.
// - Count equal to one means no jump; continue at next line.
// - Targets past queue end are ignored; forward targets never repeat.
// - Store writes queue to segment 1-12 and ends any serial fill.
// - Good upload: ack, header of line count plus one, then lines.
// - Bad upload: ack then code 0 empty, -1 running, -2 busy, -3 locked.
// - Unknown commands answer with negative acknowledge.
// - Upload takes segments 1-12; zero uploads the queue.
// - Load-and-run copies segment and runs from line 1, also inside programs.
// - Halt stops program execution.
// - Edge counter mode increments event register once per matching edge.
// - Level counter mode increments event register 8000 times per second.
// - Counter command without mode disables; event register 25 stays presettable.
// - Run command executes queue from its first line.
// - Halting leaves queue contents intact.
`timescale 1ns/1ps
`default_nettype none
module pqc_queue_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host commands
	input wire logic cmd_valid,
	input wire pqc_pkg::pqc_cmd_t cmd,
	output logic cmd_ready_ff,
	// Host answers
	output pqc_pkg::pqc_resp_t resp_ff,
	// Program lines handed to the motion engine
	output pqc_pkg::pqc_exec_t exec_ff,
	input wire logic exec_done,
	// Environment
	input wire logic key_locked,
	input wire logic [7:0] ev_in,
	// Status
	output logic running_ff,
	output logic filling_ff,
	output logic [15:0] event_count_ff
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_WAIT = 3'b010,
		ST_UPLOAD = 3'b011
	} pqc_state_t;

	pqc_state_t st_ff, nxt_st;
	logic [15:0] queue_ff [pqc_pkg::QUEUE_LINES];
	logic [15:0] seg_ff [pqc_pkg::SEG_COUNT][pqc_pkg::QUEUE_LINES];
	logic [5:0] seg_len_ff [pqc_pkg::SEG_COUNT];
	logic [5:0] q_len_ff;
	logic [5:0] pc_ff;
	logic [15:0] regs_ff [pqc_pkg::DATA_REGS];
	logic err_pend_ff;
	logic [15:0] err_code_ff;
	logic upl_hdr_ff;
	logic upl_queue_ff;
	logic [3:0] upl_seg_ff;
	logic [5:0] upl_len_ff;
	logic [5:0] upl_idx_ff;

	function automatic logic seg_valid(input logic [11:0] a);
		seg_valid = (a != 12'h000) && (a <= pqc_pkg::SEG_MAX);
	endfunction : seg_valid

	function automatic logic [3:0] seg_index(input logic [11:0] a);
		seg_index = a[3:0] - 4'h1;
	endfunction : seg_index

	function automatic logic op_known(input logic [3:0] op);
		op_known = (op >= pqc_pkg::OP_FILL) && (op <= pqc_pkg::OP_GENERIC);
	endfunction : op_known

	function automatic logic accept_state(input pqc_state_t s);
		accept_state = (s == ST_IDLE) || (s == ST_WAIT) || (s == ST_UPLOAD);
	endfunction : accept_state

	logic take;
	logic cmd_nack;
	logic in_range;
	logic [15:0] cur_line;
	logic [3:0] line_op;
	logic [11:0] line_arg;
	logic [4:0] rep_reg;
	logic [5:0] rep_tgt;
	logic rep_jump;
	logic rep_dec;
	logic idle_cmd;
	logic fill_cmd;
	logic upl_ok;
	logic upl_step;
	logic upl_last;
	logic do_fill_line;
	logic do_copy;
	logic [3:0] copy_idx;
	logic do_save;
	logic start_run;
	logic cnt_cfg;
	logic [5:0] cnt_arg;
	logic cnt_inc;

	assign take = cmd_valid && cmd_ready_ff;
	assign idle_cmd = take && (st_ff == ST_IDLE) && !filling_ff;
	assign fill_cmd = take && (st_ff == ST_IDLE) && filling_ff;
	assign in_range = pc_ff < q_len_ff;
	assign cur_line = queue_ff[pc_ff];
	assign line_op = cur_line[15:12];
	assign line_arg = cur_line[11:0];
	assign rep_reg = line_arg[pqc_pkg::ARG_REG_LSB +: 5];
	assign rep_tgt = line_arg[pqc_pkg::ARG_TGT_MSB:0];
	// Target must lie inside the queue and not after this line
	assign rep_jump = (st_ff == ST_FETCH) && in_range && (line_op == pqc_pkg::OP_REPEAT)
		&& (rep_tgt != 6'h00) && (rep_tgt <= q_len_ff) && (rep_tgt <= pc_ff + 6'h01)
		&& ($signed(regs_ff[rep_reg]) > $signed(16'h0001));
	assign rep_dec = rep_jump;
	assign upl_ok = !key_locked && ((cmd.arg == 12'h000) ? (q_len_ff != 6'h00)
		: (seg_len_ff[seg_index(cmd.arg)] != 6'h00));
	assign upl_step = (st_ff == ST_UPLOAD) && !take && !err_pend_ff;
	assign upl_last = upl_step && !upl_hdr_ff && (upl_idx_ff == upl_len_ff - 6'h01);

	// Answer decision for the command on the bus this cycle
	always_comb
	begin
		cmd_nack = !op_known(cmd.op);
		if (st_ff == ST_IDLE && filling_ff)
		begin
			if (cmd.op == pqc_pkg::OP_STORE && !seg_valid(cmd.arg))
				cmd_nack = 1'b1;
			else if (cmd.op != pqc_pkg::OP_STORE && cmd.op != pqc_pkg::OP_RUN
				&& q_len_ff == pqc_pkg::QUEUE_LINES_W)
				cmd_nack = 1'b1;
		end
		else if (st_ff == ST_IDLE)
		begin
			if ((cmd.op == pqc_pkg::OP_FILL && cmd.arg != 12'h000 && !seg_valid(cmd.arg))
				|| ((cmd.op == pqc_pkg::OP_STORE || cmd.op == pqc_pkg::OP_LOADRUN) && !seg_valid(cmd.arg)))
				cmd_nack = 1'b1;
		end
		else if (st_ff == ST_WAIT)
		begin
			if (cmd.op != pqc_pkg::OP_HALT && cmd.op != pqc_pkg::OP_UPLOAD
				&& cmd.op != pqc_pkg::OP_REGLOAD && cmd.op != pqc_pkg::OP_COUNTER)
				cmd_nack = 1'b1;
		end
		else if (cmd.op != pqc_pkg::OP_UPLOAD)
			cmd_nack = 1'b1;
		if (cmd.op == pqc_pkg::OP_UPLOAD && cmd.arg > pqc_pkg::SEG_MAX && !filling_ff)
			cmd_nack = 1'b1;
	end

	assign do_fill_line = fill_cmd && !cmd_nack && cmd.op != pqc_pkg::OP_STORE && cmd.op != pqc_pkg::OP_RUN;
	assign do_save = take && (st_ff == ST_IDLE) && !cmd_nack && cmd.op == pqc_pkg::OP_STORE;
	assign start_run = take && (st_ff == ST_IDLE) && !cmd_nack && cmd.op == pqc_pkg::OP_RUN;
	assign do_copy = (idle_cmd && !cmd_nack && (cmd.op == pqc_pkg::OP_LOADRUN
		|| (cmd.op == pqc_pkg::OP_FILL && cmd.arg != 12'h000)))
		|| ((st_ff == ST_FETCH) && in_range && line_op == pqc_pkg::OP_LOADRUN && seg_valid(line_arg));
	assign copy_idx = (st_ff == ST_FETCH) ? seg_index(line_arg) : seg_index(cmd.arg);
	assign cnt_cfg = (take && !cmd_nack && !filling_ff && cmd.op == pqc_pkg::OP_COUNTER)
		|| ((st_ff == ST_FETCH) && in_range && line_op == pqc_pkg::OP_COUNTER);
	assign cnt_arg = (st_ff == ST_FETCH) ? line_arg[5:0] : cmd.arg[5:0];

	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff)
			ST_IDLE:
				if (start_run || (idle_cmd && !cmd_nack && cmd.op == pqc_pkg::OP_LOADRUN))
					nxt_st = ST_FETCH;
				else if (idle_cmd && !cmd_nack && cmd.op == pqc_pkg::OP_UPLOAD && upl_ok)
					nxt_st = ST_UPLOAD;
			ST_FETCH:
				if (!in_range || line_op == pqc_pkg::OP_HALT)
					nxt_st = ST_IDLE;
				else if (line_op == pqc_pkg::OP_GENERIC)
					nxt_st = ST_WAIT;
			ST_WAIT:
				if (take && cmd.op == pqc_pkg::OP_HALT)
					nxt_st = ST_IDLE;
				else if (exec_done)
					nxt_st = ST_FETCH;
			ST_UPLOAD:
				if (upl_last)
					nxt_st = ST_IDLE;
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= ST_IDLE;
			cmd_ready_ff <= 1'b0;
			running_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			// One idle cycle after an upload request keeps its error answer from being overrun
			cmd_ready_ff <= accept_state(nxt_st) && !(take && cmd.op == pqc_pkg::OP_UPLOAD);
			running_ff <= (nxt_st == ST_FETCH) || (nxt_st == ST_WAIT);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			filling_ff <= 1'b0;
		else if (idle_cmd && !cmd_nack && cmd.op == pqc_pkg::OP_FILL && cmd.arg == 12'h000)
			filling_ff <= 1'b1;
		else if (fill_cmd && !cmd_nack && (cmd.op == pqc_pkg::OP_STORE || cmd.op == pqc_pkg::OP_RUN))
			filling_ff <= 1'b0;
	end

	// Queue and segment storage; halting never touches it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q_len_ff <= 6'h00;
			for (int i = 0; i < pqc_pkg::QUEUE_LINES; i++)
				queue_ff[i] <= 16'h0000;
		end
		else if (do_copy)
		begin
			queue_ff <= seg_ff[copy_idx];
			q_len_ff <= seg_len_ff[copy_idx];
		end
		else if (idle_cmd && !cmd_nack && cmd.op == pqc_pkg::OP_FILL)
			q_len_ff <= 6'h00;
		else if (do_fill_line)
		begin
			queue_ff[q_len_ff] <= {cmd.op, cmd.arg};
			q_len_ff <= q_len_ff + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < pqc_pkg::SEG_COUNT; s++)
			begin
				seg_len_ff[s] <= 6'h00;
				for (int i = 0; i < pqc_pkg::QUEUE_LINES; i++)
					seg_ff[s][i] <= 16'h0000;
			end
		end
		else if (do_save)
		begin
			seg_ff[seg_index(cmd.arg)] <= queue_ff;
			seg_len_ff[seg_index(cmd.arg)] <= q_len_ff;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_ff <= 6'h00;
		else if (start_run || (do_copy && nxt_st == ST_FETCH))
			pc_ff <= 6'h00;
		else if (rep_jump)
			pc_ff <= rep_tgt - 6'h01;
		else if (st_ff == ST_FETCH && in_range && line_op != pqc_pkg::OP_HALT)
			pc_ff <= pc_ff + 6'h01;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			exec_ff <= '0;
		else
		begin
			exec_ff.valid <= (st_ff == ST_FETCH) && in_range && line_op == pqc_pkg::OP_GENERIC;
			exec_ff.line <= cur_line;
		end
	end

	pqc_event_counter u_counter (
		.clk(clk),
		.rst(rst),
		.cfg_valid(cnt_cfg),
		.cfg_arg(cnt_arg),
		.ev_in(ev_in),
		.inc_ff(cnt_inc)
	);

	// Host preset wins over the counter; a decrement of the event register and an increment together cancel
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < pqc_pkg::DATA_REGS; i++)
				regs_ff[i] <= 16'h0000;
		end
		else
		begin
			if (cnt_inc && !(rep_dec && rep_reg == pqc_pkg::EVENT_REG))
				regs_ff[pqc_pkg::EVENT_REG] <= regs_ff[pqc_pkg::EVENT_REG] + 16'h0001;
			if (rep_dec && !(cnt_inc && rep_reg == pqc_pkg::EVENT_REG))
				regs_ff[rep_reg] <= regs_ff[rep_reg] - 16'h0001;
			if (take && !cmd_nack && !filling_ff && cmd.op == pqc_pkg::OP_REGLOAD)
				regs_ff[cmd.arg[4:0]] <= cmd.value;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			event_count_ff <= 16'h0000;
		else
			event_count_ff <= regs_ff[pqc_pkg::EVENT_REG];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			err_pend_ff <= 1'b0;
			err_code_ff <= pqc_pkg::ERR_EMPTY;
		end
		else if (take && !cmd_nack && !filling_ff && cmd.op == pqc_pkg::OP_UPLOAD
			&& !(st_ff == ST_IDLE && upl_ok))
		begin
			err_pend_ff <= 1'b1;
			if (st_ff == ST_WAIT)
				err_code_ff <= pqc_pkg::ERR_RUNNING;
			else if (st_ff == ST_UPLOAD)
				err_code_ff <= pqc_pkg::ERR_BUSY;
			else if (key_locked)
				err_code_ff <= pqc_pkg::ERR_LOCKED;
			else
				err_code_ff <= pqc_pkg::ERR_EMPTY;
		end
		else
			err_pend_ff <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			upl_hdr_ff <= 1'b0;
			upl_queue_ff <= 1'b0;
			upl_seg_ff <= 4'h0;
			upl_len_ff <= 6'h00;
			upl_idx_ff <= 6'h00;
		end
		else if (idle_cmd && nxt_st == ST_UPLOAD)
		begin
			upl_hdr_ff <= 1'b1;
			upl_queue_ff <= (cmd.arg == 12'h000);
			upl_seg_ff <= seg_index(cmd.arg);
			upl_len_ff <= (cmd.arg == 12'h000) ? q_len_ff : seg_len_ff[seg_index(cmd.arg)];
			upl_idx_ff <= 6'h00;
		end
		else if (upl_step)
		begin
			upl_hdr_ff <= 1'b0;
			if (!upl_hdr_ff)
				upl_idx_ff <= upl_idx_ff + 6'h01;
		end
	end

	// Command answers take the port first; a stalled upload simply waits a cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			resp_ff <= '0;
		else if (take && !(do_fill_line || (fill_cmd && !cmd_nack)))
		begin
			resp_ff.valid <= 1'b1;
			resp_ff.kind <= cmd_nack ? pqc_pkg::RESP_NACK : pqc_pkg::RESP_ACK;
			resp_ff.value <= 16'h0000;
		end
		else if (take)
		begin
			resp_ff.valid <= 1'b1;
			resp_ff.kind <= pqc_pkg::RESP_ACK;
			resp_ff.value <= 16'h0000;
		end
		else if (err_pend_ff)
		begin
			resp_ff.valid <= 1'b1;
			resp_ff.kind <= pqc_pkg::RESP_ERROR;
			resp_ff.value <= err_code_ff;
		end
		else if (upl_step)
		begin
			resp_ff.valid <= 1'b1;
			resp_ff.kind <= upl_hdr_ff ? pqc_pkg::RESP_HEADER : pqc_pkg::RESP_LINE;
			resp_ff.value <= upl_hdr_ff ? {10'h000, upl_len_ff + 6'h01}
				: (upl_queue_ff ? queue_ff[upl_idx_ff] : seg_ff[upl_seg_ff][upl_idx_ff]);
		end
		else
			resp_ff.valid <= 1'b0;
	end

endmodule : pqc_queue_ctrl
`default_nettype wire

// File: pqc_queue_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pqc_queue_ctrl_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host side
	input wire logic cmd_valid,
	input wire pqc_pkg::pqc_cmd_t cmd,
	input wire logic cmd_ready_ff,
	input wire pqc_pkg::pqc_resp_t resp_ff,
	// Engine and environment
	input wire pqc_pkg::pqc_exec_t exec_ff,
	input wire logic exec_done,
	input wire logic key_locked,
	input wire logic [7:0] ev_in,
	// Status
	input wire logic running_ff,
	input wire logic filling_ff,
	input wire logic [15:0] event_count_ff
);
	logic tk;
	logic ack;
	logic segop;
	assign tk = cmd_valid && cmd_ready_ff;
	assign ack = resp_ff.valid && resp_ff.kind == pqc_pkg::RESP_ACK;
	assign segop = cmd.op == pqc_pkg::OP_STORE || cmd.op == pqc_pkg::OP_LOADRUN;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	answer_take_a: assert property (tk |=> resp_ff.valid && (ack || resp_ff.kind == pqc_pkg::RESP_NACK))
		else $error("taken command got no answer");
	unknown_nack_a: assert property (tk && (cmd.op == 4'h0 || cmd.op > pqc_pkg::OP_GENERIC)
		|=> resp_ff.kind == pqc_pkg::RESP_NACK)
		else $error("unknown command not refused");
	bad_seg_a: assert property (tk && !filling_ff && ((segop && cmd.arg == 12'h000)
		|| ((segop || cmd.op == pqc_pkg::OP_FILL) && cmd.arg > pqc_pkg::SEG_MAX)) |=> resp_ff.kind == pqc_pkg::RESP_NACK)
		else $error("bad segment not refused");
	fill_enter_a: assert property ((tk && cmd.op == pqc_pkg::OP_FILL && cmd.arg == 12'h000 ##1 ack) |-> filling_ff)
		else $error("fill mode not entered");
	fill_end_a: assert property ((filling_ff && tk && cmd.op == pqc_pkg::OP_STORE ##1 ack) |-> !filling_ff)
		else $error("store did not end fill");
	fill_run_a: assert property ((filling_ff && tk && cmd.op == pqc_pkg::OP_RUN ##1 ack) |-> !filling_ff)
		else $error("run did not end fill");
	run_start_a: assert property ((tk && cmd.op == pqc_pkg::OP_RUN ##1 ack) |-> ##[0:2] running_ff)
		else $error("run did not start");
	halt_stop_a: assert property (running_ff && tk && cmd.op == pqc_pkg::OP_HALT |=> ##[0:2] !running_ff)
		else $error("halt did not stop program");
	run_upload_a: assert property (tk && running_ff && cmd.op == pqc_pkg::OP_UPLOAD && cmd.arg <= pqc_pkg::SEG_MAX
		|=> ack ##1 (resp_ff.valid && resp_ff.kind == pqc_pkg::RESP_ERROR && resp_ff.value == pqc_pkg::ERR_RUNNING))
		else $error("upload while running not refused");
	exec_run_a: assert property (exec_ff.valid |-> running_ff)
		else $error("line issued while idle");

	fill_cov: cover property (tk && cmd.op == pqc_pkg::OP_FILL ##1 ack);
	halt_cov: cover property (running_ff && tk && cmd.op == pqc_pkg::OP_HALT);
	error_cov: cover property (resp_ff.valid && resp_ff.kind == pqc_pkg::RESP_ERROR);
endmodule : pqc_queue_ctrl_properties

bind pqc_queue_ctrl pqc_queue_ctrl_properties chk_u (
	.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_ff(cmd_ready_ff),
	.resp_ff(resp_ff), .exec_ff(exec_ff), .exec_done(exec_done), .key_locked(key_locked),
	.ev_in(ev_in), .running_ff(running_ff), .filling_ff(filling_ff), .event_count_ff(event_count_ff)
);
`default_nettype wire

// File: pqc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pqc_host_model (
	// Clock
	input wire logic clk,
	// Command link
	input wire logic cmd_ready_ff,
	input wire pqc_pkg::pqc_resp_t resp_ff,
	output logic cmd_valid,
	output var pqc_pkg::pqc_cmd_t cmd
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd = 32'h5a5a_c3c3;
	end

	// Held until the edge that takes it, answer sampled at the falling edge half a cycle later
	task automatic send(input logic [3:0] op, input logic [11:0] arg, input logic [15:0] val,
		output pqc_pkg::pqc_resp_t r);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = {op, arg, val};
		while (cmd_ready_ff !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		@(negedge clk);
		r = resp_ff;
		cmd_valid = 1'b0;
		// Idle bus never repeats the last command
		cmd = ~cmd;
	endtask : send

	task automatic take_resp(output pqc_pkg::pqc_resp_t r);
		@(negedge clk);
		r = resp_ff;
	endtask : take_resp
endmodule : pqc_host_model
`default_nettype wire

// File: program_queue_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_queue_controller_tb;
	logic clk, rst, cmd_valid, cmd_ready_ff, exec_done, key_locked, running_ff, filling_ff;
	logic [7:0] ev_in;
	logic [15:0] event_count_ff;
	pqc_pkg::pqc_cmd_t cmd;
	pqc_pkg::pqc_resp_t resp_ff, r;
	pqc_pkg::pqc_exec_t exec_ff;
	int n_errors = 0;
	int cmp_count = 0;
	int n_exec = 0;
	int lag = 3;
	int cyc = 0;
	logic [15:0] last_line;

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	pqc_queue_ctrl dut_u (
		.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_ff(cmd_ready_ff),
		.resp_ff(resp_ff), .exec_ff(exec_ff), .exec_done(exec_done), .key_locked(key_locked),
		.ev_in(ev_in), .running_ff(running_ff), .filling_ff(filling_ff), .event_count_ff(event_count_ff)
	);
	pqc_host_model host_u (.clk(clk), .cmd_ready_ff(cmd_ready_ff), .resp_ff(resp_ff), .cmd_valid(cmd_valid), .cmd(cmd));

	// Motion engine stand-in: finishes each line after lag cycles
	always
	begin
		@(negedge clk);
		if (exec_ff.valid === 1'b1)
		begin
			n_exec++;
			last_line = exec_ff.line;
			repeat (lag) @(negedge clk);
			exec_done = 1'b1;
			@(negedge clk);
			exec_done = 1'b0;
		end
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_errors++;
			$display("CHECK FAILED run time expected under 10000 cycles seen %0d", cyc);
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cmdx(input logic [3:0] op, input logic [11:0] arg, input bit ack, input logic [15:0] val = 16'h0000);
		host_u.send(op, arg, val, r);
		chk("answer", {r.valid, r.kind}, {1'b1, ack ? pqc_pkg::RESP_ACK : pqc_pkg::RESP_NACK});
	endtask : cmdx

	task automatic rsp(input logic [2:0] kind, input logic [15:0] val);
		host_u.take_resp(r);
		chk("response", {r.valid, r.kind, r.value}, {1'b1, kind, val});
	endtask : rsp

	task automatic upl(input logic [11:0] seg, input logic [15:0] l1, input logic [15:0] l2);
		cmdx(pqc_pkg::OP_UPLOAD, seg, 1'b1);
		rsp(pqc_pkg::RESP_HEADER, 16'h0003);
		rsp(pqc_pkg::RESP_LINE, l1);
		rsp(pqc_pkg::RESP_LINE, l2);
	endtask : upl

	task automatic uerr(input logic [11:0] seg, input logic [15:0] code);
		cmdx(pqc_pkg::OP_UPLOAD, seg, 1'b1);
		rsp(pqc_pkg::RESP_ERROR, code);
	endtask : uerr

	task automatic wait_idle();
		repeat (3) @(negedge clk);
		for (int i = 0; i < 500 && running_ff !== 1'b0; i++)
			@(negedge clk);
	endtask : wait_idle

	task automatic pulses(input int n);
		repeat (n)
		begin
			ev_in[2] = 1'b1;
			repeat (4) @(negedge clk);
			ev_in[2] = 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask : pulses

	task automatic t_fill();
		cmdx(pqc_pkg::OP_FILL, 12'h000, 1'b1);
		chk("filling", filling_ff, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h011, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h022, 1'b1);
		cmdx(pqc_pkg::OP_STORE, 12'h003, 1'b1);
		chk("filling", filling_ff, 1'b0);
		upl(12'h003, 16'ha011, 16'ha022);
		$display("fill and store test done");
	endtask : t_fill

	task automatic t_refuse();
		cmdx(4'h0, 12'h000, 1'b0);
		cmdx(4'hf, 12'h000, 1'b0);
		cmdx(pqc_pkg::OP_STORE, 12'h00d, 1'b0);
		cmdx(pqc_pkg::OP_FILL, 12'h00d, 1'b0);
		cmdx(pqc_pkg::OP_LOADRUN, 12'h000, 1'b0);
		cmdx(pqc_pkg::OP_UPLOAD, 12'h00d, 1'b0);
		uerr(12'h005, pqc_pkg::ERR_EMPTY);
		key_locked = 1'b1;
		uerr(12'h003, pqc_pkg::ERR_LOCKED);
		key_locked = 1'b0;
		upl(12'h000, 16'ha011, 16'ha022);
		// Next upload lands while this one is still streaming; this one's header goes unread
		cmdx(pqc_pkg::OP_UPLOAD, 12'h000, 1'b1);
		uerr(12'h000, pqc_pkg::ERR_BUSY);
		rsp(pqc_pkg::RESP_LINE, 16'ha011);
		rsp(pqc_pkg::RESP_LINE, 16'ha022);
		$display("refusal test done");
	endtask : t_refuse

	task automatic t_loadrun();
		cmdx(pqc_pkg::OP_FILL, 12'h000, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h0ee, 1'b1);
		cmdx(pqc_pkg::OP_STORE, 12'h004, 1'b1);
		cmdx(pqc_pkg::OP_FILL, 12'h003, 1'b1);
		upl(12'h000, 16'ha011, 16'ha022);
		n_exec = 0;
		cmdx(pqc_pkg::OP_LOADRUN, 12'h003, 1'b1);
		wait_idle();
		chk("lines run", n_exec, 32'h2);
		chk("last line", last_line, 16'ha022);
		$display("load and run test done");
	endtask : t_loadrun

	task automatic t_repeat();
		// Event register used as loop count so no general register is consumed
		cmdx(pqc_pkg::OP_REGLOAD, 12'h019, 1'b1, 16'h0003);
		cmdx(pqc_pkg::OP_FILL, 12'h000, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h001, 1'b1);
		cmdx(pqc_pkg::OP_REPEAT, 12'h643, 1'b1);
		cmdx(pqc_pkg::OP_REPEAT, 12'h67e, 1'b1);
		cmdx(pqc_pkg::OP_REPEAT, 12'h641, 1'b1);
		n_exec = 0;
		cmdx(pqc_pkg::OP_RUN, 12'h000, 1'b1);
		wait_idle();
		chk("loop passes", n_exec, 32'd3);
		chk("count left", event_count_ff, 16'h0001);
		$display("repeat test done");
	endtask : t_repeat

	task automatic t_halt();
		lag = 80;
		cmdx(pqc_pkg::OP_FILL, 12'h000, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h005, 1'b1);
		cmdx(pqc_pkg::OP_GENERIC, 12'h006, 1'b1);
		cmdx(pqc_pkg::OP_RUN, 12'h000, 1'b1);
		uerr(12'h000, pqc_pkg::ERR_RUNNING);
		cmdx(pqc_pkg::OP_HALT, 12'h000, 1'b1);
		repeat (3) @(negedge clk);
		chk("running", running_ff, 1'b0);
		upl(12'h000, 16'ha005, 16'ha006);
		// Let the slow engine finish its stray line before going on
		repeat (90) @(negedge clk);
		lag = 3;
		$display("halt test done");
	endtask : t_halt

	task automatic t_counter();
		cmdx(pqc_pkg::OP_REGLOAD, 12'h019, 1'b1, 16'h0000);
		cmdx(pqc_pkg::OP_COUNTER, 12'h011, 1'b1);
		pulses(3);
		chk("rise count", event_count_ff, 16'h0003);
		cmdx(pqc_pkg::OP_COUNTER, 12'h012, 1'b1);
		pulses(3);
		chk("fall count", event_count_ff, 16'h0006);
		cmdx(pqc_pkg::OP_COUNTER, 12'h000, 1'b1);
		pulses(3);
		chk("off count", event_count_ff, 16'h0006);
		ev_in = 8'h04;
		cmdx(pqc_pkg::OP_COUNTER, 12'h014, 1'b1);
		repeat (5010) @(negedge clk);
		chk("timer count", event_count_ff, 16'h0008);
		ev_in = 8'h00;
		cmdx(pqc_pkg::OP_COUNTER, 12'h013, 1'b1);
		repeat (2510) @(negedge clk);
		chk("low timer count", event_count_ff, 16'h0009);
		$display("counter test done");
	endtask : t_counter

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		rst = 1'b1;
		exec_done = 1'b0;
		key_locked = 1'b0;
		ev_in = 8'h00;
		repeat (8) @(negedge clk);
		chk("ready in reset", cmd_ready_ff, 1'b0);
		rst = 1'b0;
		@(negedge clk);
		chk("ready after reset", cmd_ready_ff, 1'b1);
		t_fill();
		t_refuse();
		t_loadrun();
		t_repeat();
		t_halt();
		t_counter();
		tally_and_finish();
	end
endmodule : program_queue_controller_tb
`default_nettype wire
